/* File: logic/paacc_pkg.sv */
package paacc_pkg;
	localparam int PAACC_AW = 8;

	// register byte addresses
	localparam logic [PAACC_AW-1:0] PAACC_OFF_CONTROL = 8'h00;
	localparam logic [PAACC_AW-1:0] PAACC_OFF_FLAGS = 8'h04;
	localparam logic [PAACC_AW-1:0] PAACC_OFF_COUNT = 8'h08;

	// control field positions
	localparam int PAACC_CTL_ENABLE = 6;
	localparam int PAACC_CTL_MODE = 5;
	localparam int PAACC_CTL_EDGE = 4;
	localparam int PAACC_CTL_CLK_HI = 3;
	localparam int PAACC_CTL_CLK_LO = 2;
	localparam int PAACC_CTL_OVI = 1;
	localparam int PAACC_CTL_II = 0;
	localparam logic [7:0] PAACC_CTL_WMASK = 8'h7f;

	// flag field positions
	localparam int PAACC_FLG_OVF = 1;
	localparam int PAACC_FLG_IN = 0;

	// reset values
	localparam logic [7:0] PAACC_CONTROL_RST = 8'h00;
	localparam logic [15:0] PAACC_COUNT_RST = 16'h0000;
	localparam logic [15:0] PAACC_DIV_RST = 16'h0000;

	// divider terminal counts for /256 and /65536
	localparam logic [7:0] PAACC_DIV256_LAST = 8'hff;
	localparam logic [15:0] PAACC_DIV65536_LAST = 16'hffff;
	localparam logic [15:0] PAACC_COUNT_MAX = 16'hffff;

	localparam logic [1:0] PAACC_RESP_OKAY = 2'h0;
	localparam logic [1:0] PAACC_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PAACC_CLK_PRESCALER = 2'b00,
		PAACC_CLK_ACC = 2'b01,
		PAACC_CLK_ACC_DIV256 = 2'b10,
		PAACC_CLK_ACC_DIV65536 = 2'b11
	} paacc_clksel_t;

	typedef struct packed {
		logic [PAACC_AW-1:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [PAACC_AW-1:0] araddr;
		logic arvalid;
		logic rready;
	} paacc_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} paacc_axi_rsp_t;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic pin_prev;
		logic [7:0] control;
		logic ovf;
		logic inf;
		logic [15:0] count;
		logic [15:0] div;
		logic aw_full;
		logic [PAACC_AW-1:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} paacc_state_t;
endpackage : paacc_pkg

/* File: logic/paacc_top.sv */
// Behaviour
// - accumulator runs only while control bit 6 is one.
// - event counting works even with the timer module disabled.
// - control bit 5 picks gated accumulation (1) or event counting (0).
// - event mode counts rising edges when bit 4 is one, falling when zero.
// - gated mode counts divide-by-64 ticks during gate, flags trailing edge.
// - divide-by-64 ticks come from the prescaler, only while timer active.
// - clock select picks prescaler, accumulator clock, its /256 or /65536.
// - a new clock select takes effect immediately.
// - disabled accumulator always gives the prescaler clock to the timer.
// - overflow flag requests an interrupt only while bit 1 is one.
// - input flag requests an interrupt only while bit 0 is one.
// - overflow flag sets when count wraps from maximum to zero.
// - writing one clears the overflow flag, zero leaves it.
// - writing one clears the input-edge flag.
// - input flag sets on active edge, or gate trailing edge in gated mode.
// - with fast clear on, a count register read, or a count write strobing byte 0 or 1, clears both flags.
// - a 16-bit register counts accumulator clocks: active input events, or gated ticks in gated mode.
// - input pin is synchronised before counting, so counts lag slightly.
// - count register is readable and writable anytime, write loads it.
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module paacc_top
	import paacc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire paacc_axi_req_t axi_req,
	output paacc_axi_rsp_t axi_rsp,
	input wire logic pulse_in,
	input wire logic timer_module_enable,
	input wire logic fast_flag_clear,
	input wire logic prescaler_tick,
	input wire logic div64_tick,
	output logic timer_count_tick,
	output logic accumulator_clock,
	output logic overflow_irq_req,
	output logic input_edge_irq_req
);
	paacc_state_t state_r;
	paacc_state_t state_nxt;

	logic acc_en;
	logic gated_mode;
	logic edge_rising;
	paacc_clksel_t clk_sel;
	logic rise;
	logic fall;
	logic active_edge;
	logic gate_open;
	logic gated_tick;
	logic tick256;
	logic tick65536;
	logic wr_go;
	logic wr_control;
	logic wr_flags;
	logic wr_count;
	logic rd_go;
	logic rd_count;
	logic count_access;
	logic clr_ovf;
	logic clr_inf;
	logic set_ovf;
	logic [15:0] count_inc;
	logic [PAACC_AW-1:0] rd_addr;

	assign acc_en = state_r.control[PAACC_CTL_ENABLE];
	assign gated_mode = state_r.control[PAACC_CTL_MODE];
	assign edge_rising = state_r.control[PAACC_CTL_EDGE];
	assign clk_sel = paacc_clksel_t'(state_r.control[PAACC_CTL_CLK_HI:PAACC_CTL_CLK_LO]);

	// edges seen only on the second synchroniser stage
	assign rise = state_r.sync2 & ~state_r.pin_prev;
	assign fall = ~state_r.sync2 & state_r.pin_prev;
	// trailing gate edge equals the event edge of the same polarity setting
	assign active_edge = acc_en & (edge_rising ? rise : fall);
	assign gate_open = edge_rising ? ~state_r.sync2 : state_r.sync2;
	assign gated_tick = acc_en & gated_mode & gate_open & div64_tick & timer_module_enable;

	// event mode ignores the timer enable on purpose
	always_comb begin
		if (gated_mode) begin
			accumulator_clock = gated_tick;
		end else begin
			accumulator_clock = active_edge;
		end
	end

	assign tick256 = accumulator_clock & (state_r.div[7:0] == PAACC_DIV256_LAST);
	assign tick65536 = accumulator_clock & (state_r.div == PAACC_DIV65536_LAST);

	// combinational mux so a select change acts in the same cycle
	always_comb begin
		if (!acc_en) begin
			timer_count_tick = prescaler_tick;
		end else begin
			unique case (clk_sel)
				PAACC_CLK_PRESCALER: timer_count_tick = prescaler_tick;
				PAACC_CLK_ACC: timer_count_tick = accumulator_clock;
				PAACC_CLK_ACC_DIV256: timer_count_tick = tick256;
				PAACC_CLK_ACC_DIV65536: timer_count_tick = tick65536;
			endcase
		end
	end

	assign overflow_irq_req = state_r.ovf & state_r.control[PAACC_CTL_OVI];
	assign input_edge_irq_req = state_r.inf & state_r.control[PAACC_CTL_II];

	assign axi_rsp.awready = ~state_r.aw_full;
	assign axi_rsp.wready = ~state_r.w_full;
	assign axi_rsp.bvalid = state_r.bvalid;
	assign axi_rsp.bresp = state_r.bresp;
	assign axi_rsp.arready = ~state_r.rvalid;
	assign axi_rsp.rvalid = state_r.rvalid;
	assign axi_rsp.rdata = state_r.rdata;
	assign axi_rsp.rresp = state_r.rresp;

	assign wr_go = state_r.aw_full & state_r.w_full & ~state_r.bvalid;
	assign wr_control = wr_go & (state_r.aw_addr[PAACC_AW-1:2] == PAACC_OFF_CONTROL[PAACC_AW-1:2]);
	assign wr_flags = wr_go & (state_r.aw_addr[PAACC_AW-1:2] == PAACC_OFF_FLAGS[PAACC_AW-1:2]);
	assign wr_count = wr_go & (state_r.aw_addr[PAACC_AW-1:2] == PAACC_OFF_COUNT[PAACC_AW-1:2]);
	assign rd_go = axi_req.arvalid & ~state_r.rvalid;
	assign rd_addr = axi_req.araddr;
	assign rd_count = rd_go & (rd_addr[PAACC_AW-1:2] == PAACC_OFF_COUNT[PAACC_AW-1:2]);
	assign count_access = rd_count | (wr_count & (|state_r.w_strb[1:0]));

	// reserved flag bits are dropped on write
	assign clr_ovf = (wr_flags & state_r.w_strb[0] & state_r.w_data[PAACC_FLG_OVF])
		| (fast_flag_clear & count_access);
	assign clr_inf = (wr_flags & state_r.w_strb[0] & state_r.w_data[PAACC_FLG_IN])
		| (fast_flag_clear & count_access);
	assign set_ovf = accumulator_clock & (state_r.count == PAACC_COUNT_MAX);
	assign count_inc = state_r.count + 16'h0001;

	always_comb begin
		state_nxt = state_r;

		state_nxt.sync1 = pulse_in;
		state_nxt.sync2 = state_r.sync1;
		state_nxt.pin_prev = state_r.sync2;

		if (accumulator_clock) begin
			state_nxt.div = state_r.div + 16'h0001;
		end

		// count stays put without an accumulator clock
		if (accumulator_clock) begin
			state_nxt.count = count_inc;
		end

		// set beats a clear arriving in the same cycle
		state_nxt.ovf = (state_r.ovf & ~clr_ovf) | set_ovf;
		state_nxt.inf = (state_r.inf & ~clr_inf) | active_edge;

		if (axi_req.awvalid && !state_r.aw_full) begin
			state_nxt.aw_full = 1'b1;
			state_nxt.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && !state_r.w_full) begin
			state_nxt.w_full = 1'b1;
			state_nxt.w_data = axi_req.wdata;
			state_nxt.w_strb = axi_req.wstrb;
		end

		if (wr_go) begin
			state_nxt.aw_full = 1'b0;
			state_nxt.w_full = 1'b0;
			state_nxt.bvalid = 1'b1;
			state_nxt.bresp = (wr_control | wr_flags | wr_count) ? PAACC_RESP_OKAY : PAACC_RESP_SLVERR;
		end
		if (state_r.bvalid && axi_req.bready) begin
			state_nxt.bvalid = 1'b0;
		end

		if (wr_control && state_r.w_strb[0]) begin
			state_nxt.control = state_r.w_data[7:0] & PAACC_CTL_WMASK;
		end
		// a software load overrides a same-cycle increment
		if (wr_count) begin
			if (state_r.w_strb[0]) begin
				state_nxt.count[7:0] = state_r.w_data[7:0];
			end
			if (state_r.w_strb[1]) begin
				state_nxt.count[15:8] = state_r.w_data[15:8];
			end
		end

		if (rd_go) begin
			state_nxt.rvalid = 1'b1;
			state_nxt.rresp = PAACC_RESP_OKAY;
			if (rd_addr[PAACC_AW-1:2] == PAACC_OFF_CONTROL[PAACC_AW-1:2]) begin
				state_nxt.rdata = {24'h000000, state_r.control};
			end else if (rd_addr[PAACC_AW-1:2] == PAACC_OFF_FLAGS[PAACC_AW-1:2]) begin
				state_nxt.rdata = {30'h0, state_r.ovf, state_r.inf};
			end else if (rd_count) begin
				state_nxt.rdata = {16'h0000, state_r.count};
			end else begin
				state_nxt.rdata = 32'h00000000;
				state_nxt.rresp = PAACC_RESP_SLVERR;
			end
		end
		if (state_r.rvalid && axi_req.rready) begin
			state_nxt.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_r <= '0;
			state_r.control <= PAACC_CONTROL_RST;
			state_r.count <= PAACC_COUNT_RST;
			state_r.div <= PAACC_DIV_RST;
		end else begin
			state_r <= state_nxt;
		end
	end
endmodule : paacc_top

/* File: testbench/paacc_monitor.sv */
`timescale 1ns/100ps
module paacc_monitor
	import paacc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire paacc_axi_req_t axi_req,
	input wire paacc_axi_rsp_t axi_rsp,
	input wire logic pulse_in,
	input wire logic timer_module_enable,
	input wire logic prescaler_tick,
	input wire logic div64_tick,
	input wire logic timer_count_tick,
	input wire logic accumulator_clock,
	input wire logic overflow_irq_req,
	input wire logic input_edge_irq_req
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// pin edges reach the counter two edges late, through the synchroniser
	property p_acc_src; accumulator_clock |-> div64_tick && timer_module_enable || $past(pulse_in, 2) != $past(pulse_in, 3); endproperty
	a_acc_src: assert property (p_acc_src) else $error("accumulator clock without cause");
	property p_tick_src; timer_count_tick |-> prescaler_tick || accumulator_clock; endproperty
	a_tick_src: assert property (p_tick_src) else $error("timer tick without source");
	property p_ovf_rise; $rose(overflow_irq_req) |-> $past(accumulator_clock) || $rose(axi_rsp.bvalid); endproperty
	a_ovf_rise: assert property (p_ovf_rise) else $error("overflow request without cause");
	property p_in_rise; $rose(input_edge_irq_req) |-> $past(pulse_in, 3) != $past(pulse_in, 4) || $rose(axi_rsp.bvalid); endproperty
	a_in_rise: assert property (p_in_rise) else $error("input request without edge");
	property p_ovf_fall; $fell(overflow_irq_req) |-> $rose(axi_rsp.bvalid) || $rose(axi_rsp.rvalid); endproperty
	a_ovf_fall: assert property (p_ovf_fall) else $error("overflow request dropped alone");
	property p_in_fall; $fell(input_edge_irq_req) |-> $rose(axi_rsp.bvalid) || $rose(axi_rsp.rvalid); endproperty
	a_in_fall: assert property (p_in_fall) else $error("input request dropped alone");
	property p_rd_lat; axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_wr_lat; axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid; endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer off time");
endmodule : paacc_monitor
bind paacc_top paacc_monitor mon_u (.clk_sys(clk_sys), .rstn(rstn), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.pulse_in(pulse_in), .timer_module_enable(timer_module_enable), .prescaler_tick(prescaler_tick),
	.div64_tick(div64_tick), .timer_count_tick(timer_count_tick), .accumulator_clock(accumulator_clock),
	.overflow_irq_req(overflow_irq_req), .input_edge_irq_req(input_edge_irq_req));

/* File: testbench/paacc_pulse_src.sv */
`timescale 1ns/100ps
module paacc_pulse_src (
	input wire logic clk_sys,
	output logic pin
);
	// the model owns the pin alone: no channel 3 output drives it
	initial pin = 1'b0;
	// one high pulse, so exactly one rising and one falling edge
	task automatic pulse(input int width, input int gap);
		@(posedge clk_sys);
		pin <= 1'b1;
		repeat (width) @(posedge clk_sys);
		pin <= 1'b0;
		repeat (gap) @(posedge clk_sys);
	endtask : pulse
endmodule : paacc_pulse_src

/* File: testbench/pulse_accumulator_tb.sv */
`timescale 1ns/100ps
module pulse_accumulator_tb
	import paacc_pkg::*;
;
	logic clk_sys, rstn, pin, tmr_en, ffc, pre_tick, d64, pre_on, tick, aclk, ovf_irq, in_irq;
	paacc_axi_req_t req;
	paacc_axi_rsp_t rsp;
	logic [31:0] d;
	logic [1:0] r;
	int fails, num_checks, exp_cnt, s, tick_n, pre_n, t0, p0;
	paacc_top dut_u (.clk_sys(clk_sys), .rstn(rstn), .axi_req(req), .axi_rsp(rsp), .pulse_in(pin),
		.timer_module_enable(tmr_en), .fast_flag_clear(ffc), .prescaler_tick(pre_tick), .div64_tick(d64),
		.timer_count_tick(tick), .accumulator_clock(aclk), .overflow_irq_req(ovf_irq), .input_edge_irq_req(in_irq));
	paacc_pulse_src src_u (.clk_sys(clk_sys), .pin(pin));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		tick_n <= tick_n + tick;
		pre_n <= pre_n + pre_tick;
		pre_tick <= pre_on && ($urandom % 2);
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic summarize();
		if (fails == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	// ready is looked at mid-cycle, where it is settled, and acted on at the next edge
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] v);
		paacc_axi_rsp_t o;
		int k;
		@(posedge clk_sys);
		req <= '{a, we, v, 4'hf, we, we, a, !we, !we};
		for (k = 0; k < 50; k++) begin
			@(negedge clk_sys);
			o = rsp;
			@(posedge clk_sys);
			req.awvalid <= req.awvalid && !o.awready;
			req.wvalid <= req.wvalid && !o.wready;
			req.arvalid <= req.arvalid && !o.arready;
			if (we ? o.bvalid : o.rvalid) begin
				req.bready <= 1'b0;
				req.rready <= 1'b0;
				d = o.rdata;
				r = we ? o.bresp : o.rresp;
				return;
			end
		end
		fails++;
		summarize();
	endtask : xfer
	initial begin
		req = '0;
		{rstn, tmr_en, ffc, d64, pre_on} = 5'h00;
		s = $urandom(37);
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		for (s = 0; s < 16; s += 4) begin
			xfer(0, 8'(s), 0);
			chk(d, 0);
			chk({30'h0, r}, {30'h0, s < 12 ? PAACC_RESP_OKAY : PAACC_RESP_SLVERR});
		end
		// timer left off: event counting must still run
		for (s = 0; s < 2; s++) begin
			xfer(1, PAACC_OFF_CONTROL, 32'h41 | (s << 4));
			t0 = 1 + $urandom % 4;
			repeat (t0) src_u.pulse(3 + $urandom % 6, 6);
			exp_cnt += t0;
			xfer(0, PAACC_OFF_COUNT, 0);
			chk(d, exp_cnt);
			chk({31'h0, in_irq}, 1);
			xfer(0, PAACC_OFF_FLAGS, 0);
			chk(d, 1);
			xfer(1, PAACC_OFF_FLAGS, 1);
			xfer(0, PAACC_OFF_FLAGS, 0);
			chk(d, 0);
		end
		xfer(1, PAACC_OFF_CONTROL, 32'h12);
		src_u.pulse(3, 6);
		xfer(0, PAACC_OFF_COUNT, 0);
		chk(d, exp_cnt);
		xfer(1, PAACC_OFF_CONTROL, 32'h52);
		xfer(1, PAACC_OFF_COUNT, 32'hffff);
		src_u.pulse(3, 6);
		chk({31'h0, ovf_irq}, 1);
		for (s = 0; s < 2; s++) begin
			xfer(1, PAACC_OFF_FLAGS, s * 2);
			xfer(0, PAACC_OFF_FLAGS, 0);
			chk(d, 3 - s * 2);
		end
		ffc <= 1'b1;
		xfer(0, PAACC_OFF_COUNT, 0);
		chk(d, 0);
		xfer(0, PAACC_OFF_FLAGS, 0);
		chk(d, 0);
		ffc <= 1'b0;
		// 256 pulses give exactly one divided tick whatever the divider phase
		for (s = 0; s < 5; s++) begin
			xfer(1, PAACC_OFF_CONTROL, s < 4 ? 32'h50 | (s << 2) : 32'h04);
			pre_on <= (s % 4 == 0);
			t0 = tick_n;
			p0 = pre_n;
			repeat (s == 2 ? 256 : 4) src_u.pulse(3, 3);
			pre_on <= 1'b0;
			repeat (3) @(posedge clk_sys);
			chk(tick_n - t0, s % 4 == 0 ? pre_n - p0 : s == 1 ? 4 : s == 2 ? 1 : 0);
		end
		xfer(1, PAACC_OFF_FLAGS, 3);
		xfer(1, PAACC_OFF_CONTROL, 32'h70);
		exp_cnt = $urandom % 32'hff00;
		xfer(1, PAACC_OFF_COUNT, exp_cnt);
		for (s = 0; s < 2; s++) begin
			tmr_en <= (s == 0);
			repeat (5) begin
				@(posedge clk_sys);
				d64 <= 1'b1;
				@(posedge clk_sys);
				d64 <= 1'b0;
			end
			xfer(0, PAACC_OFF_COUNT, 0);
			chk(d, exp_cnt + 5);
		end
		src_u.pulse(3, 6);
		xfer(0, PAACC_OFF_FLAGS, 0);
		chk(d, 1);
		summarize();
	end
endmodule : pulse_accumulator_tb
